// [rtl/epd_pkg.sv]
/*
 Package for the encoder pulse output divider: widths, reset values and
 direction encodings.
 Assumes one core clock at 250 MHz and that every input to the block is
 synchronous to that clock.
*/
package epd_pkg;
   // ---------------------------------------------------------------
   // Divider settings
   // ---------------------------------------------------------------
   localparam int          EPD_DIV_W      = 16;
   localparam logic [15:0] EPD_DIV_MIN    = 16'h0001;
   localparam logic [15:0] EPD_DIV_MAX    = 16'h8000;
   localparam logic [15:0] EPD_DIV_INIT   = 16'h0001;
   localparam int          EPD_ACC_W      = 17;
   // ---------------------------------------------------------------
   // Timing and output channel count
   // ---------------------------------------------------------------
   localparam int          EPD_CLK_MHZ    = 250;
   localparam int          EPD_JITTER_US  = 33;
   localparam int          EPD_JITTER_CYC = EPD_JITTER_US * EPD_CLK_MHZ;
   localparam int          EPD_OUT_CHANS  = 5;
   // ---------------------------------------------------------------
   // Direction of output pulses
   // ---------------------------------------------------------------
   typedef enum logic {EPD_DIR_NORMAL, EPD_DIR_INVERT} epd_dir_t;
endpackage

// [rtl/epd_step_if.sv]
/*
 Interface carrying divided count steps from the divider core to the
 quadrature output stage.
 Assumes a single clock domain shared by both ends.
*/
`timescale 1ns/100ps
interface epd_step_if;
   logic step;
   logic up;
   modport core (output step, output up);
   modport sink (input step, input up);
endinterface

// [rtl/epd_accum.sv]
/*
 Fractional divider accumulator: turns encoder counts into a thinned
 stream of output steps.
 Assumes settings are stable while counts arrive and num is at most den.
*/
`timescale 1ns/100ps
module epd_accum
   import epd_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 clk_en,
   // Settings
   input  wire logic [EPD_DIV_W-1:0] num,
   input  wire logic [EPD_DIV_W-1:0] den,
   input  wire logic                 clear,
   // Encoder counts
   input  wire logic                 cnt_pulse,
   input  wire logic                 cnt_up,
   // Steps out
   epd_step_if.core                  st
);
   logic [EPD_ACC_W-1:0] acc_q;
   logic [EPD_ACC_W-1:0] sum;
   logic [EPD_ACC_W-1:0] dif;

   // Up counts add num, down counts subtract; window is [0, den)
   always_comb
   begin
      sum = acc_q + {1'b0, num};
      dif = acc_q - {1'b0, num};
   end

   // Steps land only on whole input counts, hence the jitter
   // Accumulator, one output step per crossing of den
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q   <= '0;
         st.step <= 1'b0;
         st.up   <= 1'b1;
      end
      else if (clk_en)
      begin
         st.step <= 1'b0;
         if (clear)
            acc_q <= '0;
         else if (cnt_pulse && cnt_up)
         begin
            st.up <= 1'b1;
            if (sum >= {1'b0, den})
            begin
               acc_q   <= sum - {1'b0, den};
               st.step <= 1'b1;
            end
            else
               acc_q <= sum;
         end
         else if (cnt_pulse)
         begin
            st.up <= 1'b0;
            if (acc_q < {1'b0, num})
            begin
               acc_q   <= dif + {1'b0, den};
               st.step <= 1'b1;
            end
            else
               acc_q <= dif;
         end
      end
   end

   // Accumulator never leaves its window while num <= den
   a_acc_window: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_q < {1'b0, den} || $changed(den))
      else $error("accumulator out of range");
endmodule

// [rtl/epd_top.sv]
/*
 Encoder pulse output divider: re-emits encoder feedback to the host as
 line-driver pairs and an open-collector index pulse, phases A and B scaled by num/den.
 Assumes encoder counts arrive decoded as count pulses with direction,
 all inputs synchronous to core_clk, and that the host side follows the
 settings discipline (servo off while changing, num no greater than den).
*/
`timescale 1ns/100ps

// What this block does
// - Drive phase A and its complement as a differential pair.
// - Drive phase B and its complement as a differential pair.
// - Drive the index signal and its complement as a differential pair.
// - Send absolute position serial data on its own differential pair.
// - Provide the Z pulse on an open-collector output.
// - Exactly five encoder-related output signals face the host.
// - A setting inverts the direction of the output pulses.
// - Output pulses equal encoder pulses times numerator over denominator.
// - Numerator accepted from 1 to 32768, initial value 1.
// - Denominator accepted from 1 to 32768, initial value 1.
// - Output timing may jitter up to 33 us; host must tolerate it.
// - Basic setup loads divider values with the encoder's pulse count.
module epd_top
   import epd_pkg::*;
#(
   parameter int DIV_W = EPD_DIV_W
)
(
   // Clock, reset, enable
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   // Encoder side
   input  wire logic             enc_cnt_pulse,
   input  wire logic             enc_cnt_up,
   input  wire logic             enc_index,
   input  wire logic             enc_abs_data,
   // Settings
   input  wire logic             servo_on,
   input  wire logic             set_strobe,
   input  wire logic [DIV_W-1:0] set_numerator,
   input  wire logic [DIV_W-1:0] set_denominator,
   input  wire logic             set_direction,
   input  wire logic             basic_setup,
   input  wire logic [DIV_W-1:0] setup_pulse_count,
   // Host outputs, five encoder signals in all
   output logic                  phase_a_out_pos,
   output logic                  phase_a_out_neg,
   output logic                  phase_b_out_pos,
   output logic                  phase_b_out_neg,
   output logic                  index_out_pos,
   output logic                  index_out_neg,
   output logic                  abs_position_out_pos,
   output logic                  abs_position_out_neg,
   output logic                  z_pulse_out,
   output logic                  z_pulse_oe,
   // Setting status
   output logic [DIV_W-1:0]      divider_numerator,
   output logic [DIV_W-1:0]      divider_denominator,
   output logic                  output_direction_setting,
   output logic                  set_rejected
);
   import epd_pkg::*;

   // ---------------------------------------------------------------
   // Settings
   // ---------------------------------------------------------------
   logic num_ok;
   logic den_ok;
   logic set_take;
   logic upd_q;

   // Out-of-range values are refused rather than clipped
   assign num_ok   = set_numerator >= EPD_DIV_MIN &&
                     set_numerator <= EPD_DIV_MAX;
   assign den_ok   = set_denominator >= EPD_DIV_MIN &&
                     set_denominator <= EPD_DIV_MAX;
   // Settings only land while the servo is off
   assign set_take = set_strobe && !servo_on && num_ok && den_ok;

   // Divider registers; basic setup wins over an ordinary write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divider_numerator   <= EPD_DIV_INIT;
         divider_denominator <= EPD_DIV_INIT;
      end
      else if (clk_en)
      begin
         if (basic_setup && !servo_on &&
             setup_pulse_count >= EPD_DIV_MIN &&
             setup_pulse_count <= EPD_DIV_MAX)
         begin
            divider_numerator   <= setup_pulse_count;
            divider_denominator <= setup_pulse_count;
         end
         else if (set_take)
         begin
            divider_numerator   <= set_numerator;
            divider_denominator <= set_denominator;
         end
      end
   end

   // Direction setting, also held while the servo runs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         output_direction_setting <= EPD_DIR_NORMAL;
      else if (clk_en && set_strobe && !servo_on)
         output_direction_setting <= set_direction;
   end

   // Rejection flag for a write that did not land
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         set_rejected <= 1'b0;
      else if (clk_en && set_strobe)
         set_rejected <= !set_take;
   end

   // One-cycle flag to restart the accumulator after new settings
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         upd_q <= 1'b0;
      else if (clk_en)
         upd_q <= set_take || (basic_setup && !servo_on);
   end

   // ---------------------------------------------------------------
   // Divider core
   // ---------------------------------------------------------------
   epd_step_if st_if ();

   epd_accum u_accum (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .num       (divider_numerator),
      .den       (divider_denominator),
      .clear     (upd_q),
      .cnt_pulse (enc_cnt_pulse),
      .cnt_up    (enc_cnt_up),
      .st        (st_if.core)
   );

   // ---------------------------------------------------------------
   // Quadrature output
   // ---------------------------------------------------------------
   logic [1:0] quad_q;
   logic       fwd;

   // Inversion reverses step direction, so the other phase leads
   assign fwd = st_if.up ^ output_direction_setting;

   // Gray sequence 00-01-11-10; one step moves exactly one phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         quad_q <= 2'h0;
      else if (clk_en && st_if.step)
      begin
         if (fwd)
            quad_q <= {quad_q[0], ~quad_q[1]};
         else
            quad_q <= {~quad_q[0], quad_q[1]};
      end
   end

   // Line-driver pairs, registered so both halves switch together
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase_a_out_pos      <= 1'b0;
         phase_a_out_neg      <= 1'b1;
         phase_b_out_pos      <= 1'b0;
         phase_b_out_neg      <= 1'b1;
         index_out_pos        <= 1'b0;
         index_out_neg        <= 1'b1;
         abs_position_out_pos <= 1'b0;
         abs_position_out_neg <= 1'b1;
      end
      else if (clk_en)
      begin
         phase_a_out_pos      <= quad_q[0];
         phase_a_out_neg      <= ~quad_q[0];
         phase_b_out_pos      <= quad_q[1];
         phase_b_out_neg      <= ~quad_q[1];
         index_out_pos        <= enc_index;
         index_out_neg        <= ~enc_index;
         abs_position_out_pos <= enc_abs_data;
         abs_position_out_neg <= ~enc_abs_data;
      end
   end

   // Open collector: pull low while Z is active, otherwise release
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         z_pulse_out <= 1'b0;
         z_pulse_oe  <= 1'b0;
      end
      else if (clk_en)
      begin
         z_pulse_out <= 1'b0;
         z_pulse_oe  <= enc_index;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_pair_a_comp: assert property (@(posedge core_clk) disable iff (!rst_n)
      phase_a_out_pos != phase_a_out_neg)
      else $error("phase A pair not complementary");
   a_pair_b_comp: assert property (@(posedge core_clk) disable iff (!rst_n)
      phase_b_out_pos != phase_b_out_neg)
      else $error("phase B pair not complementary");
   a_index_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en |=> index_out_pos == $past(enc_index))
      else $error("index pair does not follow encoder");
   a_abs_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en |=> abs_position_out_pos != abs_position_out_neg &&
      abs_position_out_pos == $past(enc_abs_data))
      else $error("position data pair wrong");
   a_z_opencoll: assert property (@(posedge core_clk) disable iff (!rst_n)
      !z_pulse_out and
      (clk_en |=> z_pulse_oe == $past(enc_index)))
      else $error("Z output not open collector");
   a_quad_gray: assert property (@(posedge core_clk) disable iff (!rst_n)
      $countones(quad_q ^ $past(quad_q)) <= 1)
      else $error("quadrature skipped a state");
   a_servo_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      servo_on && $past(servo_on) |-> $stable(divider_numerator))
      else $error("numerator changed with servo on");
   a_num_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      divider_numerator >= EPD_DIV_MIN &&
      divider_numerator <= EPD_DIV_MAX)
      else $error("numerator out of range");
   a_den_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      divider_denominator >= EPD_DIV_MIN &&
      divider_denominator <= EPD_DIV_MAX)
      else $error("denominator out of range");
endmodule

// [test/epd_host_model.sv]
/*
 Host controller model: decodes the quadrature pair from the drive into
 a signed position count and flags any illegal jump between states.
 Assumes the pins are registered on core_clk and sampled on its rising edge.
*/
`timescale 1ns/100ps
module epd_host_model
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Quadrature pair from the drive
   input  wire logic          phase_a_in,
   input  wire logic          phase_b_in,
   // Decoded results
   output logic signed [31:0] host_pos,
   output logic               quad_err
);
   logic [1:0] pos_q;
   logic [1:0] pos_d;
   logic [1:0] step;

   // ---------------------------------------------------------------
   // Decoder
   // ---------------------------------------------------------------
   // Gray position of the pair, B then A: 00, 01, 11, 10 count up
   assign pos_d = {phase_b_in, phase_b_in ^ phase_a_in};
   assign step  = pos_d - pos_q;

   // Edges are counted whatever their spacing, so jitter is tolerated
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos_q    <= 2'h0;
         host_pos <= 32'sh0;
         quad_err <= 1'b0;
      end
      else
      begin
         pos_q <= pos_d;
         if (step == 2'h1)
            host_pos <= host_pos + 32'sh1;
         else if (step == 2'h3)
            host_pos <= host_pos - 32'sh1;
         else if (step == 2'h2)
            quad_err <= 1'b1; // Both phases moved at once
      end
   end
endmodule

// [test/tb_encoder_pulse_output_divider.sv]
/*
 Self-checking bench for the encoder pulse output divider.
 Assumes the host model decodes the phase pins; every input is driven
 here on the falling edge of core_clk.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin cmp_count++; if ((got) !== (ex)) begin fails++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_encoder_pulse_output_divider;
   import epd_pkg::*;
   typedef struct {logic [15:0] num; logic [15:0] den; logic dir;
                   logic up; int n; int ex;} epd_row_t;
   logic core_clk, rst_n, clk_en, enc_cnt_pulse, enc_cnt_up, enc_index;
   logic enc_abs_data, servo_on, set_strobe, set_direction, basic_setup;
   logic [15:0] set_numerator, set_denominator, setup_pulse_count;
   logic pa_p, pa_n, pb_p, pb_n, ix_p, ix_n, ab_p, ab_n, z_out, z_oe;
   logic [15:0] divider_numerator, divider_denominator;
   logic output_direction_setting, set_rejected, quad_err;
   logic signed [31:0] host_pos, base;
   int fails, cmp_count;
   epd_row_t rows[8];

   epd_top u_epd_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .enc_cnt_pulse(enc_cnt_pulse), .enc_cnt_up(enc_cnt_up),
      .enc_index(enc_index), .enc_abs_data(enc_abs_data),
      .servo_on(servo_on), .set_strobe(set_strobe),
      .set_numerator(set_numerator), .set_denominator(set_denominator),
      .set_direction(set_direction), .basic_setup(basic_setup),
      .setup_pulse_count(setup_pulse_count), .phase_a_out_pos(pa_p),
      .phase_a_out_neg(pa_n), .phase_b_out_pos(pb_p),
      .phase_b_out_neg(pb_n), .index_out_pos(ix_p), .index_out_neg(ix_n),
      .abs_position_out_pos(ab_p), .abs_position_out_neg(ab_n),
      .z_pulse_out(z_out), .z_pulse_oe(z_oe),
      .divider_numerator(divider_numerator),
      .divider_denominator(divider_denominator),
      .output_direction_setting(output_direction_setting),
      .set_rejected(set_rejected));
   epd_host_model u_epd_host_model (.core_clk(core_clk), .rst_n(rst_n),
      .phase_a_in(pa_p), .phase_b_in(pb_p), .host_pos(host_pos),
      .quad_err(quad_err));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Strobe one setting; the two extra cycles let the accumulator clear
   task automatic write_set(logic [15:0] n, logic [15:0] d, logic dir);
      @(negedge core_clk);
      set_numerator   = n;
      set_denominator = d;
      set_direction   = dir;
      set_strobe      = 1'b1;
      @(negedge core_clk);
      set_strobe = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask

   // Counts two cycles apart, then six cycles so the pins have settled
   task automatic send_counts(int n, logic up);
      for (int i = 0; i < n; i++)
      begin
         @(negedge core_clk);
         enc_cnt_pulse = 1'b1;
         enc_cnt_up    = up;
         @(negedge core_clk);
         enc_cnt_pulse = 1'b0;
      end
      repeat (6) @(negedge core_clk);
   endtask

   task automatic check_reset();
      `CHK("num_init", EPD_DIV_INIT, divider_numerator)
      `CHK("den_init", EPD_DIV_INIT, divider_denominator)
      `CHK("dir_init", 1'b0, output_direction_setting)
      `CHK("a_idle", 2'b01, {pa_p, pa_n})
      `CHK("z_idle", 1'b0, z_oe)
   endtask

   // ---------------------------------------------------------------
   // Clock and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // A hang is cut short well past the longest sequence
   initial
   begin
      repeat (60000) @(posedge core_clk);
      fails++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0; clk_en = 1'b1; enc_cnt_pulse = 1'b0; enc_cnt_up = 1'b1;
      enc_index = 1'b0; enc_abs_data = 1'b0; servo_on = 1'b0;
      set_strobe = 1'b0; set_direction = 1'b0; basic_setup = 1'b0;
      set_numerator = 16'h0001; set_denominator = 16'h0001;
      setup_pulse_count = 16'h0800; fails = 0; cmp_count = 0;
      // Exact multiples only, so the floor of the ratio never matters
      // Numerator never above denominator in any row
      rows = '{'{16'h0001, 16'h0001, 1'b0, 1'b1, 8, 8},
               '{16'h0001, 16'h0001, 1'b0, 1'b0, 8, -8},
               '{16'h0001, 16'h0001, 1'b1, 1'b1, 8, -8},
               '{16'h0001, 16'h0001, 1'b1, 1'b0, 8, 8},
               '{16'h03e8, 16'h0800, 1'b0, 1'b1, 2048, 1000},
               '{16'h0001, 16'h0002, 1'b0, 1'b0, 16, -8},
               '{16'h8000, 16'h8000, 1'b0, 1'b1, 4, 4},
               '{16'h0003, 16'h0004, 1'b1, 1'b1, 16, -12}};
      repeat (12) @(negedge core_clk);
      check_reset();
      rst_n = 1'b1;
      foreach (rows[i])
      begin
         write_set(rows[i].num, rows[i].den, rows[i].dir);
         `CHK("num", rows[i].num, divider_numerator)
         `CHK("den", rows[i].den, divider_denominator)
         `CHK("rej", 1'b0, set_rejected)
         `CHK("dir", rows[i].dir, output_direction_setting)
         base = host_pos;
         send_counts(rows[i].n, rows[i].up);
         `CHK("edges", 32'(rows[i].ex), host_pos - base)
         `CHK("a_pair", ~pa_p, pa_n)
         `CHK("b_pair", ~pb_p, pb_n)
      end
      // Settings refused with the servo on, or out of range
      servo_on = 1'b1;
      write_set(16'h0005, 16'h0009, 1'b1);
      `CHK("busy_rej", 1'b1, set_rejected)
      `CHK("busy_num", 16'h0003, divider_numerator)
      servo_on = 1'b0;
      write_set(16'h0000, 16'h0004, 1'b1);
      `CHK("zero_rej", 2'b11, {set_rejected, divider_numerator[0]})
      write_set(16'h0004, 16'h8001, 1'b1);
      `CHK("big_rej", 16'h0004, divider_denominator)
      // Basic setup loads both settings from the encoder pulse count
      basic_setup = 1'b1;
      @(negedge core_clk);
      basic_setup = 1'b0;
      repeat (2) @(negedge core_clk);
      `CHK("setup", {2{16'h0800}}, {divider_numerator, divider_denominator})
      base = host_pos;
      send_counts(8, 1'b1);
      `CHK("setup_edges", -32'sd8, host_pos - base)
      // A frozen clock enable takes no counts
      clk_en = 1'b0;
      send_counts(4, 1'b1);
      clk_en = 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK("frozen", -32'sd8, host_pos - base)
      // Index, absolute data and Z follow their inputs one cycle later
      for (int v = 1; v >= 0; v--)
      begin
         enc_index    = v[0];
         enc_abs_data = ~v[0];
         repeat (2) @(negedge core_clk);
         `CHK("index", {v[0], ~v[0]}, {ix_p, ix_n})
         `CHK("abs", {~v[0], v[0]}, {ab_p, ab_n})
         `CHK("z", {1'b0, v[0]}, {z_out, z_oe})
      end
      `CHK("quad", 1'b0, quad_err)
      // Second reset in mid-run restores the initial settings
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      check_reset();
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      final_report();
   end
endmodule
